// ==== io_flag_regs.svh ====
// constants for the programmed i/o flag and function block
// assumes inclusion by bare name from the package and the design modules
`ifndef IO_FLAG_REGS_SVH
`define IO_FLAG_REGS_SVH

// instruction word fields, bit 15 is the most significant bit (lsb-0 numbering)
`define IOI_FIXED_VAL 3'h3
`define IOI_FIXED_HI 15
`define IOI_FIXED_LO 13
`define IOI_AC_HI 12
`define IOI_AC_LO 11
`define IOI_OP_HI 10
`define IOI_OP_LO 8
`define IOI_FN_HI 7
`define IOI_FN_LO 6
`define IOI_DEV_HI 5
`define IOI_DEV_LO 0

// device codes, octal 27 and 67
`define DEV_CODE_PRIMARY 6'h17
`define DEV_CODE_SECONDARY 6'h37

// fault field of the data-transfer status word, msb-0 bits 6..15 = lsb bits 9..0
`define STAT_FAULT_MASK 16'h03ff

// command field positions in the command word (msb-0 bits 5..8, drive 9..10)
`define CMDW_CMD_HI 10
`define CMDW_CMD_LO 7
`define CMDW_DRV_HI 6
`define CMDW_DRV_LO 5
`define CMDW_CLR_RW 15
`define CMDW_CLR_ATT_HI 14
`define CMDW_CLR_ATT_LO 11

// per-port configuration limits and the command loaded at reset
`define MEDIA_FMT_COUNT 3'h5
`define ILV_NONE 3'h1
`define ILV_MAX 3'h6
`define RESET_CMD 4'h0

`endif

// ==== io_flag_pkg.sv ====
// types for the programmed i/o flag and function block
// assumes the constants header sits in the same folder
package io_flag_pkg;
	`include "io_flag_regs.svh"

	// function field, host bus convention
	typedef enum logic [1:0] {
		FN_NONE = 2'h0,
		FN_START = 2'h1,
		FN_CLEAR = 2'h2,
		FN_PULSE = 2'h3
	} func_e;

	// transfer opcode field
	typedef enum logic [2:0] {
		OP_NIO = 3'h0,
		OP_DIA = 3'h1,
		OP_DOA = 3'h2,
		OP_DIB = 3'h3,
		OP_DOB = 3'h4,
		OP_DIC = 3'h5,
		OP_DOC = 3'h6,
		OP_SKP = 3'h7
	} op_e;

	// disk commands
	typedef enum logic [3:0] {
		C_READ = 4'h0,
		C_RECAL = 4'h1,
		C_SEEK = 4'h2,
		C_STOP = 4'h3,
		C_OFS_FWD = 4'h4,
		C_OFS_REV = 4'h5,
		C_WR_DIS = 4'h6,
		C_RELEASE = 4'h7,
		C_TRESPASS = 4'h8,
		C_ALT1 = 4'h9,
		C_ALT2 = 4'ha,
		C_EXAM_RAM = 4'hb,
		C_VERIFY = 4'hc,
		C_RD_BUF = 4'hd,
		C_WRITE = 4'he,
		C_FORMAT = 4'hf
	} disk_cmd_e;

	// skip conditions in the function field of a skip instruction
	typedef enum logic [1:0] {
		SK_BUSY_SET = 2'h0,
		SK_BUSY_CLR = 2'h1,
		SK_DONE_SET = 2'h2,
		SK_DONE_CLR = 2'h3
	} skip_e;
endpackage

// ==== ecc_port_counter.sv ====
// one sixteen-bit ecc correction counter for a single drive port
// assumes a synchronous active-low reset from the front-panel / power path
`timescale 1ns/1ns
module ecc_port_counter #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// control
	input wire logic load_in,
	input wire logic [WIDTH-1:0] load_val_in,
	input wire logic incr_in,
	// state
	output logic [WIDTH-1:0] count_out
);
	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;

	// a load wins over a correction in the same cycle; the count saturates at all ones
	assign count_nxt = load_in ? load_val_in :
		(incr_in && count_r != {WIDTH{1'b1}}) ? count_r + {{(WIDTH-1){1'b0}}, 1'b1} : count_r;

	// counter cleared only by reset
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count_out = count_r;
endmodule

// ==== io_instruction_flag_control.sv ====
// flag and function decoder for a four-port disk controller on a programmed i/o bus
// assumes the host presents one instruction per strobe, synchronous to CORE_CLK_IN;
// the disk sequencer outside reports completion, faults and seek attention as pulses
//
// How it works
// - clear forces busy and done low and aborts any running data transfer.
// - clear wipes status fault bits six through fifteen.
// - clear drops read/write-complete, all attention flags and pending interrupt.
// - start sets busy, clears done, launches read, write, format, read buffers, verify.
// - start withdraws pending interrupt and wipes status fault bits six through fifteen.
// - pulse on a loaded non-transfer command, other than C_ALT1 and C_ALT2, sets control-full and launches it.
// - responds to device code 27 octal primary or 67 octal secondary.
// - each transfer instruction carries at most one function, acted on beside the transfer.
// - instruction fields: fixed 011, accumulator, opcode, function, device code.
// - each drive has its own ecc counter, cleared only by reset.
// - counters are sixteen bits, loadable to any value.
// - each port selects one of five media formats.
// - each port sets interleave one, or two through six.
// - logical interleave on a port forbids physical interleave there.
// - dual-volume drive needs even unit and takes two logical units.
// - drive settings held per port, four ports, unit-independent.
// - skip instructions test busy and done set or clear.
// - bus master reset resets flags, command and address but not port settings, ecc counters or read data, selects unit zero, loads read command.
`timescale 1ns/1ns
`include "io_flag_regs.svh"
module io_instruction_flag_control
	import io_flag_pkg::*;
#(
	parameter int PORTS = 4,
	parameter int ECC_W = 16
) (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	// host i/o bus
	input wire logic IO_STROBE_IN,
	input wire logic [15:0] IO_INSTR_IN,
	input wire logic [15:0] IO_DATA_IN,
	input wire logic BUS_MASTER_RESET_IN,
	output logic [15:0] IO_DATA_OUT,
	output logic [1:0] ACCUMULATOR_SELECT_OUT,
	output logic IO_SELECTED_OUT,
	output logic SKIP_OUT,
	// configuration
	input wire logic SECONDARY_UNIT_IN,
	input wire logic [2:0] PORT_FMT_IN [PORTS],
	input wire logic [2:0] PORT_ILV_IN [PORTS],
	input wire logic [PORTS-1:0] PORT_LOGICAL_ILV_IN,
	input wire logic [PORTS-1:0] PORT_DUAL_VOL_IN,
	input wire logic [1:0] PORT_UNIT_IN [PORTS],
	input wire logic CFG_WRITE_IN,
	input wire logic [1:0] CFG_PORT_IN,
	// disk sequencer side
	input wire logic XFER_DONE_IN,
	input wire logic CTRL_DONE_IN,
	input wire logic [9:0] FAULT_SET_IN,
	input wire logic [PORTS-1:0] ATTN_SET_IN,
	input wire logic [PORTS-1:0] ECC_CORR_IN,
	input wire logic ECC_LOAD_IN,
	input wire logic [1:0] ECC_PORT_IN,
	input wire logic [ECC_W-1:0] ECC_VAL_IN,
	output logic LAUNCH_OUT,
	output logic [3:0] LAUNCH_CMD_OUT,
	output logic [1:0] LAUNCH_UNIT_OUT,
	output logic ABORT_OUT,
	// flags and state
	output logic BUSY_OUT,
	output logic DONE_OUT,
	output logic CTRL_FULL_OUT,
	output logic RW_COMPLETE_OUT,
	output logic [PORTS-1:0] ATTN_OUT,
	output logic INT_REQ_OUT,
	output logic [15:0] STATUS_OUT,
	output logic [3:0] CMD_OUT,
	output logic [1:0] UNIT_OUT,
	output logic [2:0] ACT_FMT_OUT [PORTS],
	output logic [2:0] ACT_ILV_OUT [PORTS],
	output logic [PORTS-1:0] CFG_REJECT_OUT,
	output logic [ECC_W-1:0] ECC_COUNT_OUT [PORTS]
);
	// ======================================================
	// instruction decode
	// ======================================================
	logic [5:0] my_code;
	logic [5:0] dev_field;
	logic fixed_ok;
	logic hit;
	op_e op;
	func_e fn;
	logic fn_clear;
	logic fn_start;
	logic fn_pulse;
	logic is_xfer;
	logic soft_rst;

	// the device code is a strap, chosen by configuration, not by software
	assign my_code = SECONDARY_UNIT_IN ? `DEV_CODE_SECONDARY : `DEV_CODE_PRIMARY;
	assign dev_field = IO_INSTR_IN[`IOI_DEV_HI:`IOI_DEV_LO];
	assign fixed_ok = IO_INSTR_IN[`IOI_FIXED_HI:`IOI_FIXED_LO] == `IOI_FIXED_VAL;
	assign op = op_e'(IO_INSTR_IN[`IOI_OP_HI:`IOI_OP_LO]);
	assign fn = func_e'(IO_INSTR_IN[`IOI_FN_HI:`IOI_FN_LO]);
	assign hit = IO_STROBE_IN && fixed_ok && dev_field == my_code;
	assign is_xfer = op != OP_SKP;
	// skip reuses the function field as its condition, so no function acts then
	assign fn_clear = hit && is_xfer && fn == FN_CLEAR;
	assign fn_start = hit && is_xfer && fn == FN_START;
	assign fn_pulse = hit && is_xfer && fn == FN_PULSE;
	assign soft_rst = BUS_MASTER_RESET_IN;

	// ======================================================
	// command word and drive selection
	// ======================================================
	logic [3:0] cmd_r;
	logic [1:0] unit_r;
	logic doa_hit;
	logic dob_hit;
	logic dia_hit;
	logic dib_hit;
	logic [3:0] cmd_in;
	logic [1:0] unit_in;
	logic [3:0] cmd_used;
	logic [1:0] unit_used;
	logic cmd_is_start;
	logic cmd_is_pulse;

	assign doa_hit = hit && op == OP_DOA;
	assign dob_hit = hit && op == OP_DOB;
	assign dia_hit = hit && op == OP_DIA;
	assign dib_hit = hit && op == OP_DIB;
	assign cmd_in = IO_DATA_IN[`CMDW_CMD_HI:`CMDW_CMD_LO];
	assign unit_in = IO_DATA_IN[`CMDW_DRV_HI:`CMDW_DRV_LO];
	// a function on the command load itself acts on the freshly loaded command
	assign cmd_used = doa_hit ? cmd_in : cmd_r;
	assign unit_used = doa_hit ? unit_in : unit_r;
	assign cmd_is_start = cmd_used inside {C_READ, C_WRITE, C_FORMAT, C_RD_BUF, C_VERIFY};
	assign cmd_is_pulse = cmd_used inside {C_RECAL, C_SEEK, C_STOP, C_OFS_FWD, C_OFS_REV,
		C_WR_DIS, C_RELEASE, C_TRESPASS, C_EXAM_RAM};

	// command register, defaulting to read on unit zero after any reset
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN || soft_rst) begin
			cmd_r <= `RESET_CMD;
			unit_r <= 2'h0;
		end else if (doa_hit) begin
			cmd_r <= cmd_in;
			unit_r <= unit_in;
		end
	end

	// ======================================================
	// flags
	// ======================================================
	logic busy_r;
	logic done_r;
	logic cfull_r;
	logic rwc_r;
	logic intr_r;
	logic [PORTS-1:0] attn_r;
	logic [9:0] fault_r;
	logic [15:0] addr_r;
	logic busy_nxt;
	logic done_nxt;
	logic cfull_nxt;
	logic rwc_nxt;
	logic intr_nxt;
	logic [PORTS-1:0] attn_nxt;
	logic [9:0] fault_nxt;
	logic [PORTS-1:0] attn_clr;
	logic launch_start;
	logic launch_pulse;

	assign launch_start = fn_start && cmd_is_start;
	assign launch_pulse = fn_pulse && cmd_is_pulse;
	// a command load may also clear read/write-complete and attention bits
	assign attn_clr = doa_hit ? IO_DATA_IN[`CMDW_CLR_ATT_HI:`CMDW_CLR_ATT_LO] : '0;

	// busy: start sets, clear kills; completion drops it unless start lands the same cycle
	assign busy_nxt = fn_clear ? 1'b0 :
		fn_start ? 1'b1 :
		XFER_DONE_IN ? 1'b0 : busy_r;
	// done: a completion in the same cycle as a clear is dropped with the aborted transfer
	assign done_nxt = (fn_clear || fn_start) ? 1'b0 :
		(XFER_DONE_IN && busy_r) ? 1'b1 : done_r;
	assign cfull_nxt = launch_pulse ? 1'b1 : (CTRL_DONE_IN || fn_clear) ? 1'b0 : cfull_r;
	// hardware set wins over a bit-clear from a command load
	assign rwc_nxt = fn_clear ? 1'b0 :
		(XFER_DONE_IN && busy_r) ? 1'b1 :
		(doa_hit && IO_DATA_IN[`CMDW_CLR_RW]) ? 1'b0 : rwc_r;
	assign attn_nxt = fn_clear ? '0 : (ATTN_SET_IN | (attn_r & ~attn_clr));
	assign intr_nxt = (fn_clear || fn_start) ? 1'b0 :
		((XFER_DONE_IN && busy_r) || CTRL_DONE_IN || |ATTN_SET_IN) ? 1'b1 : intr_r;
	assign fault_nxt = (fn_clear || fn_start) ? 10'h000 :
		(fault_r | FAULT_SET_IN);

	// flag registers; short by design, all next values are decoded above
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN || soft_rst) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			cfull_r <= 1'b0;
			rwc_r <= 1'b0;
			attn_r <= '0;
			intr_r <= 1'b0;
			fault_r <= 10'h000;
		end else begin
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			cfull_r <= cfull_nxt;
			rwc_r <= rwc_nxt;
			attn_r <= attn_nxt;
			intr_r <= intr_nxt;
			fault_r <= fault_nxt;
		end
	end

	// memory address load keeps the data channel start address
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN || soft_rst) begin
			addr_r <= 16'h0000;
		end else if (dob_hit) begin
			addr_r <= IO_DATA_IN;
		end
	end

	// ======================================================
	// launch strobes toward the sequencer
	// ======================================================
	logic launch_r;
	logic abort_r;
	logic [3:0] lcmd_r;
	logic [1:0] lunit_r;

	// registered one-cycle strobes; command and unit stand until the next launch
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN || soft_rst) begin
			launch_r <= 1'b0;
			abort_r <= 1'b0;
			lcmd_r <= `RESET_CMD;
			lunit_r <= 2'h0;
		end else begin
			launch_r <= launch_start || launch_pulse;
			abort_r <= fn_clear && busy_r;
			if (launch_start || launch_pulse) begin
				lcmd_r <= cmd_used;
				lunit_r <= unit_used;
			end
		end
	end

	// ======================================================
	// per-port configuration
	// ======================================================
	logic [2:0] fmt_r [PORTS];
	logic [2:0] ilv_r [PORTS];
	logic [PORTS-1:0] rej_r;
	logic [PORTS-1:0] cfg_bad;

	// a bad setting is refused and flagged; the previous setting stays in force
	for (genvar p = 0; p < PORTS; p++) begin : g_port
		logic fmt_bad;
		logic ilv_bad;
		logic dual_bad;
		assign fmt_bad = PORT_FMT_IN[p] >= `MEDIA_FMT_COUNT;
		assign ilv_bad = PORT_ILV_IN[p] == 3'h0 || PORT_ILV_IN[p] > `ILV_MAX ||
			(PORT_LOGICAL_ILV_IN[p] && PORT_ILV_IN[p] != `ILV_NONE);
		assign dual_bad = PORT_DUAL_VOL_IN[p] && PORT_UNIT_IN[p][0];
		assign cfg_bad[p] = fmt_bad || ilv_bad || dual_bad;

		// settings belong to the port, not to whichever unit number is cabled there
		always_ff @(posedge CORE_CLK_IN) begin
			if (!NRST_IN) begin
				fmt_r[p] <= 3'h0;
				ilv_r[p] <= `ILV_NONE;
				rej_r[p] <= 1'b0;
			end else if (CFG_WRITE_IN && CFG_PORT_IN == 2'(p)) begin
				rej_r[p] <= cfg_bad[p];
				if (!cfg_bad[p]) begin
					fmt_r[p] <= PORT_FMT_IN[p];
					ilv_r[p] <= PORT_ILV_IN[p];
				end
			end
		end

		ecc_port_counter #(
			.WIDTH(ECC_W)
		) u_ecc (
			.clk_in(CORE_CLK_IN),
			.nrst_in(NRST_IN),
			.load_in(ECC_LOAD_IN && ECC_PORT_IN == 2'(p)),
			.load_val_in(ECC_VAL_IN),
			.incr_in(ECC_CORR_IN[p]),
			.count_out(ECC_COUNT_OUT[p])
		);
		assign ACT_FMT_OUT[p] = fmt_r[p];
		assign ACT_ILV_OUT[p] = ilv_r[p];
	end

	// ======================================================
	// data in, skip and outputs
	// ======================================================
	logic [15:0] status_word;
	logic [15:0] rdata_r;
	logic skip_cond;

	// status word: read/write-complete, control-full and attention above the ten fault bits;
	// busy and done find no room in sixteen bits and are read through the skip tests instead
	assign status_word = {rwc_r, cfull_r, attn_r, fault_r};
	assign skip_cond = (fn == func_e'(SK_BUSY_SET) && busy_r) ||
		(fn == func_e'(SK_BUSY_CLR) && !busy_r) ||
		(fn == func_e'(SK_DONE_SET) && done_r) ||
		(fn == func_e'(SK_DONE_CLR) && !done_r);

	// returned word is latched at the strobe, shown from the next cycle
	always_ff @(posedge CORE_CLK_IN) begin
		if (!NRST_IN) begin
			rdata_r <= 16'h0000;
		end else if (dia_hit) begin
			rdata_r <= status_word;
		end else if (dib_hit) begin
			rdata_r <= addr_r;
		end
	end

	assign IO_DATA_OUT = rdata_r;
	assign ACCUMULATOR_SELECT_OUT = IO_INSTR_IN[`IOI_AC_HI:`IOI_AC_LO];
	assign IO_SELECTED_OUT = hit;
	assign SKIP_OUT = hit && op == OP_SKP && skip_cond;
	assign LAUNCH_OUT = launch_r;
	assign LAUNCH_CMD_OUT = lcmd_r;
	assign LAUNCH_UNIT_OUT = lunit_r;
	assign ABORT_OUT = abort_r;
	assign BUSY_OUT = busy_r;
	assign DONE_OUT = done_r;
	assign CTRL_FULL_OUT = cfull_r;
	assign RW_COMPLETE_OUT = rwc_r;
	assign ATTN_OUT = attn_r;
	assign INT_REQ_OUT = intr_r;
	assign STATUS_OUT = status_word & 16'hffff;
	assign CMD_OUT = cmd_r;
	assign UNIT_OUT = unit_r;
	assign CFG_REJECT_OUT = rej_r;
endmodule

// ==== io_instruction_flag_control_properties.sv ====
// port assertions for the programmed i/o flag block
// assumes a bind onto the top module and one clock domain
`timescale 1ns/1ns
module io_instruction_flag_control_properties
	import io_flag_pkg::*;
#(
	parameter int PORTS = 4
) (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic NRST_IN,
	// host bus
	input wire logic IO_STROBE_IN,
	input wire logic [15:0] IO_INSTR_IN,
	input wire logic BUS_MASTER_RESET_IN,
	input wire logic SECONDARY_UNIT_IN,
	input wire logic IO_SELECTED_OUT,
	input wire logic SKIP_OUT,
	// configuration
	input wire logic [2:0] PORT_FMT_IN [PORTS],
	input wire logic [2:0] PORT_ILV_IN [PORTS],
	input wire logic [PORTS-1:0] PORT_LOGICAL_ILV_IN,
	input wire logic [PORTS-1:0] PORT_DUAL_VOL_IN,
	input wire logic [1:0] PORT_UNIT_IN [PORTS],
	input wire logic CFG_WRITE_IN,
	input wire logic [1:0] CFG_PORT_IN,
	input wire logic [PORTS-1:0] CFG_REJECT_OUT,
	// sequencer events
	input wire logic XFER_DONE_IN,
	input wire logic CTRL_DONE_IN,
	input wire logic [9:0] FAULT_SET_IN,
	input wire logic [PORTS-1:0] ATTN_SET_IN,
	// flags and command
	input wire logic LAUNCH_OUT,
	input wire logic [3:0] LAUNCH_CMD_OUT,
	input wire logic ABORT_OUT,
	input wire logic BUSY_OUT,
	input wire logic DONE_OUT,
	input wire logic CTRL_FULL_OUT,
	input wire logic RW_COMPLETE_OUT,
	input wire logic [PORTS-1:0] ATTN_OUT,
	input wire logic INT_REQ_OUT,
	input wire logic [15:0] STATUS_OUT,
	input wire logic [3:0] CMD_OUT,
	input wire logic [1:0] UNIT_OUT
);
	// ==========
	// decode
	// quiet excludes same-cycle hardware sets, whose priority is the designer's
	wire logic [2:0] op = IO_INSTR_IN[10:8];
	wire logic [1:0] fn = IO_INSTR_IN[7:6];
	wire logic xfer = IO_SELECTED_OUT && op != 3'h0 && op != 3'h7;
	wire logic quiet = !BUS_MASTER_RESET_IN && !XFER_DONE_IN && !CTRL_DONE_IN
		&& FAULT_SET_IN == 10'h0 && !(|ATTN_SET_IN);
	wire logic [5:0] code = SECONDARY_UNIT_IN ? 6'h37 : 6'h17;
	wire logic is_data = CMD_OUT >= 4'hc || CMD_OUT == 4'h0;
	wire logic is_ctl = CMD_OUT inside {[4'h1:4'h8], 4'hb};
	wire logic [2:0] fmt = PORT_FMT_IN[CFG_PORT_IN];
	wire logic [2:0] ilv = PORT_ILV_IN[CFG_PORT_IN];
	wire logic bad = fmt >= 3'h5 || ilv == 3'h0 || ilv > 3'h6
		|| (PORT_LOGICAL_ILV_IN[CFG_PORT_IN] && ilv != 3'h1)
		|| (PORT_DUAL_VOL_IN[CFG_PORT_IN] && PORT_UNIT_IN[CFG_PORT_IN][0]);
	// ==========
	// properties
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	sequence clear_req;
		xfer && fn == FN_CLEAR && quiet;
	endsequence
	sequence start_req;
		xfer && fn == FN_START && quiet;
	endsequence
	sequence pulse_req;
		xfer && fn == FN_PULSE && quiet;
	endsequence
	clear_flags_a: assert property (clear_req |=> !BUSY_OUT && !DONE_OUT && !RW_COMPLETE_OUT && !INT_REQ_OUT)
		else $error("clear left a flag set");
	clear_faults_a: assert property (clear_req |=> !(|ATTN_OUT) && STATUS_OUT[9:0] == 10'h0)
		else $error("clear left faults or attention");
	clear_abort_a: assert property (clear_req ##0 BUSY_OUT |=> ABORT_OUT)
		else $error("clear while busy gave no abort");
	start_flags_a: assert property (start_req |=> BUSY_OUT && !DONE_OUT && !INT_REQ_OUT && STATUS_OUT[9:0] == 10'h0)
		else $error("start flags wrong");
	start_launch_a: assert property (start_req ##0 op != 3'h2 && is_data |=> LAUNCH_OUT && LAUNCH_CMD_OUT == $past(CMD_OUT))
		else $error("start did not launch");
	pulse_launch_a: assert property (pulse_req ##0 op != 3'h2 && is_ctl |=> CTRL_FULL_OUT && LAUNCH_OUT)
		else $error("pulse did not launch");
	code_match_a: assert property (IO_SELECTED_OUT == (IO_STROBE_IN && IO_INSTR_IN[15:13] == 3'h3 && IO_INSTR_IN[5:0] == code))
		else $error("selection wrong");
	foreign_quiet_a: assert property (IO_STROBE_IN && !IO_SELECTED_OUT && quiet && !CFG_WRITE_IN |=> $stable(BUSY_OUT) && $stable(DONE_OUT) && $stable(CMD_OUT) && !LAUNCH_OUT)
		else $error("foreign instruction changed state");
	skip_cond_a: assert property (IO_SELECTED_OUT && op == 3'h7 |-> SKIP_OUT == (fn[1] ? DONE_OUT ^ fn[0] : BUSY_OUT ^ fn[0]))
		else $error("skip wrong");
	bus_reset_a: assert property (BUS_MASTER_RESET_IN |=> CMD_OUT == C_READ && UNIT_OUT == 2'h0 && !BUSY_OUT && !DONE_OUT)
		else $error("bus reset state wrong");
	cfg_refuse_a: assert property (CFG_WRITE_IN |=> CFG_REJECT_OUT[$past(CFG_PORT_IN)] == $past(bad))
		else $error("config refusal wrong");
endmodule

// ==== host_cpu_model.sv ====
// host cpu model issuing programmed i/o instructions
// assumes the bench calls its tasks in clock order
`timescale 1ns/1ns
module host_cpu_model (
	// clock
	input wire logic clk_in,
	// bus drive
	output logic strobe_out,
	output logic [15:0] instr_out,
	output logic [15:0] data_out
);
	logic [1:0] acc_r = 2'h0;
	// idle bus at time zero
	initial begin
		strobe_out = 1'b0;
		instr_out = 16'h0;
		data_out = 16'h0;
	end
	// one instruction; the accumulator rotates so all four get used
	task automatic put(input logic [2:0] op, input logic [1:0] fn, input logic [5:0] dev,
		input logic [15:0] word);
		@(posedge clk_in);
		strobe_out <= 1'b1;
		instr_out <= {3'h3, acc_r, op, fn, dev};
		data_out <= word;
		acc_r <= acc_r + 2'h1;
	endtask
	// released lines toggle so a stale word is never mistaken for valid
	task automatic drop();
		@(posedge clk_in);
		strobe_out <= 1'b0;
		instr_out <= ~instr_out;
		data_out <= ~data_out;
	endtask
endmodule

// ==== io_instruction_flag_control_test.sv ====
// self-checking bench for the programmed i/o flag block
// assumes the host model and checker are compiled first
`timescale 1ns/1ns
module io_instruction_flag_control_test;
	import io_flag_pkg::*;
	// ==========
	// signals
	logic clk = 1'b0, nrst = 1'b0, bmr = 1'b0, sec = 1'b0, cfg_wr = 1'b0;
	logic xfer_done = 1'b0, ctrl_done = 1'b0, ecc_load = 1'b0;
	logic [1:0] cfg_port = 2'h0, ecc_port = 2'h0;
	logic [9:0] fault = 10'h0;
	logic [3:0] attn_set = 4'h0, ecc_corr = 4'h0, lilv = 4'h0, dual = 4'h0;
	logic [15:0] ecc_val = 16'h0;
	logic [2:0] fmt [4] = '{default: 3'h0};
	logic [2:0] ilv [4] = '{default: 3'h1};
	logic [1:0] unit [4] = '{default: 2'h0};
	logic [5:0] dev = 6'h17;
	wire logic strobe, skip, launch, abort, busy, done, cfull, rwc, intr;
	wire logic [15:0] instr, data, status, rdata;
	wire logic [3:0] attn, cmd, lcmd, reject;
	wire logic [1:0] unit_o, acc, lunit;
	wire logic [2:0] act_fmt [4];
	wire logic [2:0] act_ilv [4];
	wire logic [15:0] ecc_cnt [4];
	int error_cnt = 0;
	int checked = 0;
	// clock
	always #20 clk = ~clk;
	host_cpu_model i_host (.clk_in(clk), .strobe_out(strobe), .instr_out(instr), .data_out(data));
	io_instruction_flag_control i_dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .IO_STROBE_IN(strobe),
		.IO_INSTR_IN(instr), .IO_DATA_IN(data), .BUS_MASTER_RESET_IN(bmr), .IO_DATA_OUT(rdata),
		.ACCUMULATOR_SELECT_OUT(acc), .IO_SELECTED_OUT(), .SKIP_OUT(skip), .SECONDARY_UNIT_IN(sec),
		.PORT_FMT_IN(fmt), .PORT_ILV_IN(ilv), .PORT_LOGICAL_ILV_IN(lilv), .PORT_DUAL_VOL_IN(dual),
		.PORT_UNIT_IN(unit), .CFG_WRITE_IN(cfg_wr), .CFG_PORT_IN(cfg_port),
		.XFER_DONE_IN(xfer_done), .CTRL_DONE_IN(ctrl_done), .FAULT_SET_IN(fault),
		.ATTN_SET_IN(attn_set), .ECC_CORR_IN(ecc_corr), .ECC_LOAD_IN(ecc_load),
		.ECC_PORT_IN(ecc_port), .ECC_VAL_IN(ecc_val), .LAUNCH_OUT(launch), .LAUNCH_CMD_OUT(lcmd),
		.LAUNCH_UNIT_OUT(lunit), .ABORT_OUT(abort), .BUSY_OUT(busy), .DONE_OUT(done),
		.CTRL_FULL_OUT(cfull), .RW_COMPLETE_OUT(rwc), .ATTN_OUT(attn), .INT_REQ_OUT(intr),
		.STATUS_OUT(status), .CMD_OUT(cmd), .UNIT_OUT(unit_o), .ACT_FMT_OUT(act_fmt),
		.ACT_ILV_OUT(act_ilv), .CFG_REJECT_OUT(reject), .ECC_COUNT_OUT(ecc_cnt));
	// ==========
	// shared tasks
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one instruction; results are settled 1 ns after the taking edge
	task automatic io(input logic [2:0] op, input logic [1:0] fn, input logic [15:0] word);
		i_host.put(op, fn, dev, word);
		i_host.drop();
		#1;
	endtask
	// skip answer is combinational, so it is read while the strobe stands
	task automatic skipchk(input logic [1:0] cond, input logic exp);
		i_host.put(3'h7, cond, dev, 16'h0);
		#1;
		chk("skip", 16'(skip), 16'(exp));
		// the host model has already stepped its accumulator for the next instruction
		chk("acc", 16'(acc), 16'(2'(i_host.acc_r - 2'h1)));
		i_host.drop();
		#1;
	endtask
	task automatic ev(input logic [9:0] f, input logic [3:0] a, input logic x);
		@(posedge clk);
		fault <= f;
		attn_set <= a;
		xfer_done <= x;
		@(posedge clk);
		fault <= 10'h0;
		attn_set <= 4'h0;
		xfer_done <= 1'b0;
		#1;
	endtask
	// ==========
	// scenarios; opcode 2 writes command word, 1 reads status
	task automatic t_start();
		chk("idle", {unit_o, cmd, busy, done, cfull, intr}, 16'h0);
		io(3'h2, FN_START, 16'h0720);
		chk("start", {launch, lcmd, busy, done}, 16'h7a);
		chk("start unit", 16'(lunit), 16'h1);
		skipchk(SK_BUSY_CLR, 1'b0);
		skipchk(SK_BUSY_SET, 1'b1);
		ev(10'h0, 4'h0, 1'b1);
		chk("end", {busy, done, rwc, intr}, 16'h7);
		skipchk(SK_DONE_SET, 1'b1);
		skipchk(SK_DONE_CLR, 1'b0);
	endtask
	task automatic t_clear();
		io(3'h2, FN_START, 16'h0720);
		ev(10'h3ff, 4'hf, 1'b0);
		io(3'h1, FN_CLEAR, 16'h0);
		chk("clear", {abort, busy, done, rwc, intr}, 16'h10);
		chk("status in", rdata, 16'hbfff);
		chk("wipe", {attn, status[9:0]}, 16'h0);
		ev(10'h2aa, 4'h1, 1'b0);
		io(3'h4, FN_START, 16'h0100);
		chk("restart", {launch, lcmd, intr, status[9:0]}, 16'hf000);
	endtask
	task automatic t_ecc_pulse();
		@(posedge clk);
		ecc_port <= 2'h2;
		ecc_val <= 16'hfffe;
		ecc_load <= 1'b1;
		@(posedge clk);
		ecc_load <= 1'b0;
		ecc_corr <= 4'h4;
		repeat (2) @(posedge clk);
		ecc_corr <= 4'h0;
		#1;
		chk("ecc", ecc_cnt[2], 16'hffff);
		chk("ecc other", ecc_cnt[1], 16'h0);
		io(3'h2, FN_PULSE, 16'h0160);
		chk("pulse", {launch, lcmd, cfull}, 16'h25);
		chk("pulse unit", 16'(lunit), 16'h3);
		io(3'h6, FN_PULSE, 16'h0);
		chk("repulse", 16'(launch), 16'h1);
		@(posedge clk);
		ctrl_done <= 1'b1;
		@(posedge clk);
		ctrl_done <= 1'b0;
		#1;
		chk("ctrl done", 16'({cfull, intr}), 16'h1);
		io(3'h3, FN_NONE, 16'h0);
		chk("address", rdata, 16'h0100);
		io(3'h5, FN_START, 16'h0);
		chk("no launch", {launch, busy}, 16'h1);
		@(posedge clk);
		bmr <= 1'b1;
		@(posedge clk);
		bmr <= 1'b0;
		#1;
		chk("bus reset", {unit_o, cmd, busy, cfull}, 16'h0);
		chk("ecc kept", ecc_cnt[2], 16'hffff);
	endtask
	task automatic t_devcode();
		dev = 6'h37;
		io(3'h2, FN_START, 16'h0720);
		chk("foreign", {launch, busy, cmd}, 16'h0);
		@(posedge clk);
		sec <= 1'b1;
		io(3'h2, FN_START, 16'h0720);
		chk("second", {launch, busy}, 16'h3);
		@(posedge clk);
		sec <= 1'b0;
		dev = 6'h17;
	endtask
	// rows: format, interleave, logical, dual, unit, refused
	task automatic t_cfg();
		logic [10:0] rows [8] = '{11'h4c0, 11'h521, 11'h001, 11'h0e1,
			11'h151, 11'h230, 11'h32b, 11'h32c};
		logic [1:0] p;
		for (int i = 0; i < 8; i++) begin
			p = 2'(i);
			@(posedge clk);
			fmt[p] <= rows[i][10:8];
			ilv[p] <= rows[i][7:5];
			lilv[p] <= rows[i][4];
			dual[p] <= rows[i][3];
			unit[p] <= rows[i][2:1];
			cfg_port <= p;
			cfg_wr <= 1'b1;
			@(posedge clk);
			cfg_wr <= 1'b0;
			#1;
			chk("refuse", 16'(reject[p]), 16'(rows[i][0]));
		end
		chk("kept", {act_fmt[0], act_ilv[0], act_fmt[1], act_fmt[3]}, 16'h993);
	endtask
	// ==========
	// main sequence and hang guard
	initial begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		t_start();
		t_clear();
		t_ecc_pulse();
		t_devcode();
		t_cfg();
		@(posedge clk);
		nrst <= 1'b0;
		@(posedge clk);
		nrst <= 1'b1;
		#1;
		chk("ecc reset", ecc_cnt[2], 16'h0);
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule
bind io_instruction_flag_control io_instruction_flag_control_properties #(.PORTS(PORTS)) i_props (.*);
